// *** verilog/rir_router.v ***
// APB selector registers and pin-to-peripheral input routing
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rir_map.vh"

// Functional notes
// - Interrupt one selector: bits 15-8 of register 0; low byte unused
// - Interrupt two selector: bits 7-0 of register 1; high byte unused
// - Timer one clock selector is bits 15-8 of register 2; low byte unused
// - Register 3: timer three clock in high byte, timer two clock low
// - Registers 7 and 8: capture one/three low byte, two/four high byte
// - Compare fault selector is bits 7-0 of register 11; high byte unused
// - Registers 12 and 13: odd PWM fault low byte, even fault high byte
// - Register 18: serial one clear-to-send high byte, receive low byte
// - Register 19: serial two clear-to-send high byte, receive low byte
// - Bits without a selector read zero and ignore writes
// - Every selector bit is read/write and clears at power-on reset
module rir_router #(
  parameter NUM_PINS = 256
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  input  wire [3:0]          pstrb,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [NUM_PINS-1:0] remappable_pin_index,
  output reg                 ext_irq_a,
  output reg                 ext_irq_b,
  output reg                 timer_a_clk,
  output reg                 timer_b_clk,
  output reg                 timer_c_clk,
  output reg                 capture_a,
  output reg                 capture_b,
  output reg                 capture_c,
  output reg                 capture_d,
  output reg                 compare_fault,
  output reg                 pwm_fault_a,
  output reg                 pwm_fault_b,
  output reg                 pwm_fault_c,
  output reg                 pwm_fault_d,
  output reg                 serial_a_cts,
  output reg                 serial_a_rx,
  output reg                 serial_b_cts,
  output reg                 serial_b_rx
);

  localparam SW = `RIR_SEL_W;
  localparam NR = `RIR_NUM_ROUTES;

  // Selector storage, one byte per routed input
  reg  [SW-1:0] ext_irq_a_pin_sel;
  reg  [SW-1:0] ext_irq_b_pin_sel;
  reg  [SW-1:0] timer_a_clk_pin_sel;
  reg  [SW-1:0] timer_b_clk_pin_sel;
  reg  [SW-1:0] timer_c_clk_pin_sel;
  reg  [SW-1:0] capture_a_pin_sel;
  reg  [SW-1:0] capture_b_pin_sel;
  reg  [SW-1:0] capture_c_pin_sel;
  reg  [SW-1:0] capture_d_pin_sel;
  reg  [SW-1:0] compare_fault_pin_sel;
  reg  [SW-1:0] pwm_fault_a_pin_sel;
  reg  [SW-1:0] pwm_fault_b_pin_sel;
  reg  [SW-1:0] pwm_fault_c_pin_sel;
  reg  [SW-1:0] pwm_fault_d_pin_sel;
  reg  [SW-1:0] serial_a_cts_pin_sel;
  reg  [SW-1:0] serial_a_rx_pin_sel;
  reg  [SW-1:0] serial_b_cts_pin_sel;
  reg  [SW-1:0] serial_b_rx_pin_sel;

  // Bus decode and routing nets
  wire [4:0]    reg_idx;
  wire          addr_ok;
  wire          access;
  wire          wr_en;
  wire          hi_en;
  wire          lo_en;
  reg           idx_mapped;
  reg  [15:0]   read_word;
  wire [NR-1:0] next_route;
  wire [SW*NR-1:0] sel_bus;

  // Decode of the word index; upper address bits must be clear
  // Unmapped or misaligned words are refused with pslverr
  assign reg_idx = paddr[`RIR_ADDR_HI:`RIR_ADDR_LO];
  assign addr_ok = (paddr[11:`RIR_ADDR_HI+1] == 5'h00) &&
                   (paddr[1:0] == 2'h0);
  assign access  = psel && penable && !pready;
  assign wr_en   = access && pwrite && addr_ok && idx_mapped;
  assign hi_en   = wr_en && pstrb[1];
  assign lo_en   = wr_en && pstrb[0];

  // Pick one pin by index; out-of-range index reads low
  function pin_at;
    input [NUM_PINS-1:0] pins;
    input [SW-1:0]       sel;
    begin
      if (sel < NUM_PINS) begin
        pin_at = pins[sel];
      end else begin
        pin_at = 1'b0;
      end
    end
  endfunction

  // Mapped check and read word assembly
  always @* begin
    idx_mapped = 1'b1;
    read_word  = 16'h0000;
    case (reg_idx)
      `RIR_IDX_EXT_IRQ_ONE:   read_word = {ext_irq_a_pin_sel, 8'h00};
      `RIR_IDX_EXT_IRQ_TWO:   read_word = {8'h00, ext_irq_b_pin_sel};
      `RIR_IDX_TIMER_ONE:     read_word = {timer_a_clk_pin_sel, 8'h00};
      `RIR_IDX_TIMER_TWO_3:   read_word = {timer_c_clk_pin_sel,
                                           timer_b_clk_pin_sel};
      `RIR_IDX_CAPTURE_1_2:   read_word = {capture_b_pin_sel,
                                           capture_a_pin_sel};
      `RIR_IDX_CAPTURE_3_4:   read_word = {capture_d_pin_sel,
                                           capture_c_pin_sel};
      `RIR_IDX_CMP_FAULT:     read_word = {8'h00, compare_fault_pin_sel};
      `RIR_IDX_PWM_FAULT_1_2: read_word = {pwm_fault_b_pin_sel,
                                           pwm_fault_a_pin_sel};
      `RIR_IDX_PWM_FAULT_3_4: read_word = {pwm_fault_d_pin_sel,
                                           pwm_fault_c_pin_sel};
      `RIR_IDX_SERIAL_ONE:    read_word = {serial_a_cts_pin_sel,
                                           serial_a_rx_pin_sel};
      `RIR_IDX_SERIAL_TWO:    read_word = {serial_b_cts_pin_sel,
                                           serial_b_rx_pin_sel};
      default:                idx_mapped = 1'b0;
    endcase
  end

  // Selector writes; unused bytes have no storage at all
  // A write lands at the access edge, the same edge that raises pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_a_pin_sel     <= `RIR_SEL_RESET;
      ext_irq_b_pin_sel     <= `RIR_SEL_RESET;
      timer_a_clk_pin_sel   <= `RIR_SEL_RESET;
      timer_b_clk_pin_sel   <= `RIR_SEL_RESET;
      timer_c_clk_pin_sel   <= `RIR_SEL_RESET;
      capture_a_pin_sel     <= `RIR_SEL_RESET;
      capture_b_pin_sel     <= `RIR_SEL_RESET;
      capture_c_pin_sel     <= `RIR_SEL_RESET;
      capture_d_pin_sel     <= `RIR_SEL_RESET;
      compare_fault_pin_sel <= `RIR_SEL_RESET;
      pwm_fault_a_pin_sel   <= `RIR_SEL_RESET;
      pwm_fault_b_pin_sel   <= `RIR_SEL_RESET;
      pwm_fault_c_pin_sel   <= `RIR_SEL_RESET;
      pwm_fault_d_pin_sel   <= `RIR_SEL_RESET;
      serial_a_cts_pin_sel  <= `RIR_SEL_RESET;
      serial_a_rx_pin_sel   <= `RIR_SEL_RESET;
      serial_b_cts_pin_sel  <= `RIR_SEL_RESET;
      serial_b_rx_pin_sel   <= `RIR_SEL_RESET;
    end else begin
      case (reg_idx)
        `RIR_IDX_EXT_IRQ_ONE: begin
          if (hi_en) begin
            ext_irq_a_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
        end
        `RIR_IDX_EXT_IRQ_TWO: begin
          if (lo_en) begin
            ext_irq_b_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_TIMER_ONE: begin
          if (hi_en) begin
            timer_a_clk_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
        end
        `RIR_IDX_TIMER_TWO_3: begin
          if (hi_en) begin
            timer_c_clk_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            timer_b_clk_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_CAPTURE_1_2: begin
          if (hi_en) begin
            capture_b_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            capture_a_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_CAPTURE_3_4: begin
          if (hi_en) begin
            capture_d_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            capture_c_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_CMP_FAULT: begin
          if (lo_en) begin
            compare_fault_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_PWM_FAULT_1_2: begin
          if (hi_en) begin
            pwm_fault_b_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            pwm_fault_a_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_PWM_FAULT_3_4: begin
          if (hi_en) begin
            pwm_fault_d_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            pwm_fault_c_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_SERIAL_ONE: begin
          if (hi_en) begin
            serial_a_cts_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            serial_a_rx_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        `RIR_IDX_SERIAL_TWO: begin
          if (hi_en) begin
            serial_b_cts_pin_sel <= pwdata[`RIR_HI_MSB:`RIR_HI_LSB];
          end
          if (lo_en) begin
            serial_b_rx_pin_sel <= pwdata[`RIR_LO_MSB:`RIR_LO_LSB];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // APB answer: one wait state, ready pulses once per transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RIR_DATA_ZERO;
    end else begin
      pready  <= access;
      pslverr <= access && !(addr_ok && idx_mapped);
      if (access && !pwrite && addr_ok && idx_mapped) begin
        prdata <= {16'h0000, read_word};
      end else begin
        prdata <= `RIR_DATA_ZERO;
      end
    end
  end

  // Selectors gathered in output order for the routing loop
  // Slot gi of the bus feeds routed output gi
  assign sel_bus = {serial_b_rx_pin_sel, serial_b_cts_pin_sel,
                    serial_a_rx_pin_sel, serial_a_cts_pin_sel,
                    pwm_fault_d_pin_sel, pwm_fault_c_pin_sel,
                    pwm_fault_b_pin_sel, pwm_fault_a_pin_sel,
                    compare_fault_pin_sel, capture_d_pin_sel,
                    capture_c_pin_sel, capture_b_pin_sel,
                    capture_a_pin_sel, timer_c_clk_pin_sel,
                    timer_b_clk_pin_sel, timer_a_clk_pin_sel,
                    ext_irq_b_pin_sel, ext_irq_a_pin_sel};

  // One pin multiplexer per routed input
  // Combinational, so the route swaps as soon as a selector does
  genvar gi;
  generate
    for (gi = 0; gi < NR; gi = gi + 1) begin : g_route
      assign next_route[gi] = pin_at(remappable_pin_index,
                                     sel_bus[gi*SW +: SW]);
    end
  endgenerate

  // Registered routed inputs, one clock behind the pins
  // A rewritten selector reaches the outputs one edge later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {serial_b_rx, serial_b_cts, serial_a_rx, serial_a_cts,
       pwm_fault_d, pwm_fault_c, pwm_fault_b, pwm_fault_a,
       compare_fault, capture_d, capture_c, capture_b, capture_a,
       timer_c_clk, timer_b_clk, timer_a_clk,
       ext_irq_b, ext_irq_a} <= 18'h00000;
    end else begin
      {serial_b_rx, serial_b_cts, serial_a_rx, serial_a_cts,
       pwm_fault_d, pwm_fault_c, pwm_fault_b, pwm_fault_a,
       compare_fault, capture_d, capture_c, capture_b, capture_a,
       timer_c_clk, timer_b_clk, timer_a_clk,
       ext_irq_b, ext_irq_a} <= next_route[NR-1:0];
    end
  end

endmodule // rir_router
`default_nettype wire

// *** common/rir_map.vh ***
// Register map and field constants for the remappable input router
`ifndef RIR_MAP_VH
`define RIR_MAP_VH
// Register indices (byte address is four times the index)
`define RIR_IDX_EXT_IRQ_ONE   5'd0
`define RIR_IDX_EXT_IRQ_TWO   5'd1
`define RIR_IDX_TIMER_ONE     5'd2
`define RIR_IDX_TIMER_TWO_3   5'd3
`define RIR_IDX_CAPTURE_1_2   5'd7
`define RIR_IDX_CAPTURE_3_4   5'd8
`define RIR_IDX_CMP_FAULT     5'd11
`define RIR_IDX_PWM_FAULT_1_2 5'd12
`define RIR_IDX_PWM_FAULT_3_4 5'd13
`define RIR_IDX_SERIAL_ONE    5'd18
`define RIR_IDX_SERIAL_TWO    5'd19
// Address bits that carry the index
`define RIR_ADDR_HI           6
`define RIR_ADDR_LO           2
// Byte fields
`define RIR_HI_MSB            15
`define RIR_HI_LSB            8
`define RIR_LO_MSB            7
`define RIR_LO_LSB            0
`define RIR_SEL_W             8
// Reset value of every selector
`define RIR_SEL_RESET         8'h00
`define RIR_DATA_ZERO         32'h00000000
// Number of routed inputs
`define RIR_NUM_ROUTES        18
`endif

// *** tb/rir_pin_model.sv ***
// Device pin model: remappable pin levels changing every cycle
`timescale 1ns/1ps
`default_nettype none
module rir_pin_model #(parameter int N = 256) (
  input  wire logic         pclk,
  output wire logic [N-1:0] pins
);
  logic [31:0]  s  = 32'h1F3A5C77;
  logic [N-1:0] lv = {(N/32){32'hA5C396E1}};
  // Shift fresh levels in each cycle so no pin holds a stale value
  always @(posedge pclk) begin
    s  <= {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    lv <= {lv[N-33:0], s};
  end
  // Pin levels, one driver only
  assign pins = lv;
endmodule // rir_pin_model
`default_nettype wire

// *** tb/rir_router_properties.sv ***
// Bus timing and read-back checks for the input router
`timescale 1ns/1ps
`default_nettype none
module rir_router_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and read qualifiers
  wire acc = psel && penable && !pready;
  wire rd  = acc && !pwrite;
  ready_after_a: assert property (acc |=> pready && psel && penable)
    else $error("no ready after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  upper_zero_a: assert property (rd |=> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  bad_addr_a: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  irq_one_lo_a: assert property (rd && paddr == 12'h000 |=>
    prdata[7:0] == 8'h00) else $error("unused low byte not zero");
  irq_two_hi_a: assert property (rd && paddr == 12'h004 |=>
    prdata[15:8] == 8'h00) else $error("unused high byte not zero");
  tmr_one_lo_a: assert property (rd && paddr == 12'h008 |=>
    prdata[7:0] == 8'h00) else $error("unused low byte not zero");
  cmp_flt_hi_a: assert property (rd && paddr == 12'h02C |=>
    prdata[15:8] == 8'h00) else $error("unused high byte not zero");
  // Main scenarios
  cover property (acc && pwrite);
  cover property (pready && pslverr);
  cover property (rd && paddr == 12'h04C);
endmodule // rir_router_properties
bind rir_router rir_router_properties u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// *** tb/test_remappable_input_routing.sv ***
// Self-checking bench for the remappable input router
`timescale 1ns/1ps
`default_nettype none
module test_remappable_input_routing;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd, wd, rng = 32'h2EE4B491;
  logic [3:0]  pstrb = 4'h0;
  logic [15:0] m;
  logic [15:0] mdl [32];
  logic [255:0] last_pins;
  wire  [255:0] pins;
  wire  [31:0] prdata;
  wire  [17:0] rt;
  wire         pready, pslverr;
  int          errors = 0, comparisons = 0, idx;
  int          ridx [18] = '{0,1,2,3,3,7,7,8,8,11,12,12,13,13,18,18,19,19};
  localparam logic [17:0] RHI = 18'h16955;
  rir_router i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remappable_pin_index(pins), .ext_irq_a(rt[0]), .ext_irq_b(rt[1]),
    .timer_a_clk(rt[2]), .timer_b_clk(rt[3]), .timer_c_clk(rt[4]),
    .capture_a(rt[5]), .capture_b(rt[6]), .capture_c(rt[7]),
    .capture_d(rt[8]), .compare_fault(rt[9]), .pwm_fault_a(rt[10]),
    .pwm_fault_b(rt[11]), .pwm_fault_c(rt[12]), .pwm_fault_d(rt[13]),
    .serial_a_cts(rt[14]), .serial_a_rx(rt[15]), .serial_b_cts(rt[16]),
    .serial_b_rx(rt[17]));
  rir_pin_model i_pins (.pclk(pclk), .pins(pins));
  // Clock and a one-cycle-old copy of the pins
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) last_pins <= pins;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Implemented selector bits of each register index
  function automatic logic [15:0] imp(input int i);
    case (i)
      0, 2:                      imp = 16'hFF00;
      1, 11:                     imp = 16'h00FF;
      3, 7, 8, 12, 13, 18, 19:   imp = 16'hFFFF;
      default:                   imp = 16'h0000;
    endcase
  endfunction
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, waiting for ready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input int i);
    apb(1'b0, 12'(i * 4), 32'h00000000, 4'h0);
    chk("read data", {16'h0000, mdl[i]},
        rd);
    chk("error flag", {31'h0, imp(i) == 16'h0000}, {31'h0, er});
  endtask
  task automatic route_chk;
    logic [7:0] sl;
    @(posedge pclk);
    #1;
    for (int k = 0; k < 18; k++) begin
      sl = RHI[k] ? mdl[ridx[k]][15:8] : mdl[ridx[k]][7:0];
      chk("routed input", {31'h0, last_pins[sl]},
          {31'h0, rt[k]});
    end
    @(posedge pclk);
  endtask
  // Reset, reset values, random writes, refusals, second reset
  initial begin
    for (int i = 0; i < 32; i++) mdl[i] = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 32; i++) rchk(i);
    route_chk();
    for (int t = 0; t < 48; t++) begin
      rng = xs(rng);
      idx = (t % 6 == 5) ? int'(rng[12:8]) : ridx[rng[31:27] % 18];
      m = {{8{rng[1]}}, {8{rng[0]}}} & imp(idx);
      wd = xs(rng);
      apb(1'b1, 12'(idx * 4), wd, rng[3:0]);
      mdl[idx] = (mdl[idx] & ~m) | (wd[15:0] & m);
      rchk(idx);
      route_chk();
    end
    apb(1'b1, 12'h001, 32'hFFFFFFFF, 4'hF);
    chk("misaligned error", 32'h00000001, {31'h0, er});
    apb(1'b1, 12'h080, 32'hFFFFFFFF, 4'hF);
    chk("high address error", 32'h00000001, {31'h0, er});
    rchk(0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 32; i++) mdl[i] = 16'h0000;
    @(posedge pclk);
    rchk(3);
    rchk(18);
    route_chk();
    summarize();
  end
endmodule // test_remappable_input_routing
`default_nettype wire
